// ===== design/rsq_reset_seq.sv
// reset sequencer with low-voltage and auxiliary voltage monitoring, Avalon-MM register slave
//
// How it works
// - pin, voltage and watchdog sources; pin low in delay
// - vector fetched from FFFEh then FFFFh
// - active, then 256/4096-cycle delay, then fetch
// - vector fetch lasts exactly two cycles
// - external pin low caught only when the clock runs, not while halted
// - recognised pin pulse stretched to minimum width
// - watchdog underflow drives pin minimum width
// - low supply holds static reset, pin low
// - voltage detector optional, threshold low/medium/high
// - aux comparator output readable as warning flag
// - aux detector dead unless voltage detector enabled
// - select clear monitors supply, tied threshold
// - enabled warning interrupts on every flag toggle
// - no warning interrupt for crossings during reset
// - enable while flag set raises interrupt
// - enable after recovery gives no interrupt
// - resonators keep running through reset phase
// - clock source: external, RC, four resonators
// - select set monitors external detect pin
// - flag hardware-only, one under, zero over
// - pending interrupt cleared on service entry
`timescale 1ns/10ps
`default_nettype none

module rsq_reset_seq #(
    parameter int unsigned RSTL_CYC  = rsq_pkg::RSTL_OUT_CYC,
    parameter int unsigned DLY_SHORT = rsq_pkg::DLY_SHORT_CYC,
    parameter int unsigned DLY_LONG  = rsq_pkg::DLY_LONG_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire rsq_pkg::rsq_avs_req_s avs_req_i,
    output var  rsq_pkg::rsq_avs_rsp_s avs_rsp_o,
    input  wire logic                  rst_pin_in_i,
    output logic                       rst_pin_out_o,
    output logic                       rst_pin_oe_o,
    input  wire logic                  lvd_below_i,
    input  wire logic                  wdg_underflow_i,
    input  wire logic                  aux_cmp_supply_i,
    input  wire logic                  aux_cmp_evd_i,
    input  wire logic                  irq_ack_i,
    output logic                       avd_irq_o,
    output logic                       cpu_rst_o,
    output logic                       vec_fetch_o,
    output logic [15:0]                vec_addr_o,
    output logic                       lvd_en_o,
    output logic [1:0]                 lvd_thr_o,
    output logic                       avd_src_evd_o,
    output logic [2:0]                 osc_sel_o,
    output logic                       osc_run_o
);
    import rsq_pkg::*;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    localparam int unsigned CNT_MAX = (DLY_LONG > RSTL_CYC) ? DLY_LONG : RSTL_CYC;
    localparam int unsigned CNT_W   = $clog2(CNT_MAX + 1);

    if (RSTL_CYC < 1 || DLY_SHORT < 1 || DLY_LONG < DLY_SHORT || CNT_W > 16) begin : g_chk
        $error("rsq_reset_seq: unsupported timing parameters");
    end

    localparam logic [CNT_W-1:0] LD_RSTL  = CNT_W'(RSTL_CYC - 1);
    localparam logic [CNT_W-1:0] LD_SHORT = CNT_W'(DLY_SHORT - 1);
    localparam logic [CNT_W-1:0] LD_LONG  = CNT_W'(DLY_LONG - 1);
    localparam logic [CNT_W-1:0] LD_FETCH = CNT_W'(FETCH_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    // ****************************************************************
    // state
    // ****************************************************************
    rsq_phase_e       phase;
    rsq_phase_e       next_phase;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             pin_meta;
    logic             pin_sync;
    logic [1:0]       oe_hist;
    logic             opt_long;
    logic             warn_flag;
    logic             irq_en;

    function automatic logic [2:0] phase_code(input rsq_phase_e p);
        logic [2:0] c;
        c = 3'h0;
        unique case (p)
            PH_ACTIVE:  c = 3'h0;
            PH_RELEASE: c = 3'h1;
            PH_DELAY:   c = 3'h2;
            PH_FETCH:   c = 3'h3;
            PH_RUN:     c = 3'h4;
        endcase
        return c;
    endfunction

    // ****************************************************************
    // reset sources
    // ****************************************************************
    // the pin is sampled with a two-stage synchroniser; the core has no clock-free path,
    // so a halted core is caught as soon as the clock runs again
    always_ff @(posedge clk_i) begin
        pin_meta <= rst_pin_in_i;
        pin_sync <= pin_meta;
        oe_hist  <= {oe_hist[0], rst_pin_oe_o};
    end

    // our own drive is still visible through the synchroniser for two cycles after
    // release, so the pin is only trusted once the drive history is clear
    wire pin_trusted = !rst_pin_oe_o && (oe_hist == 2'b00);
    wire ext_req     = pin_trusted && !pin_sync;
    wire lvd_low     = lvd_en_o && lvd_below_i;
    wire pulse_req   = ext_req || wdg_underflow_i;
    wire any_req     = pulse_req || lvd_low;
    wire [CNT_W-1:0] dly_load = opt_long ? LD_LONG : LD_SHORT;
    wire cnt_done    = (cnt == CNT_ZERO);

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        next_phase = phase;
        next_cnt   = cnt;
        if (any_req && phase != PH_ACTIVE) begin
            next_phase = PH_ACTIVE;
            next_cnt   = LD_RSTL;
        end else begin
            unique case (phase)
                PH_ACTIVE: begin
                    if (pulse_req) begin
                        next_cnt = LD_RSTL;
                    end else if (!cnt_done) begin
                        next_cnt = cnt - 1'b1;
                    end else if (!lvd_low) begin
                        next_phase = PH_RELEASE;
                    end
                end
                PH_RELEASE: begin
                    // pin let go briefly so a party still holding it low is seen
                    if (pin_trusted && pin_sync) begin
                        next_phase = PH_DELAY;
                        next_cnt   = dly_load;
                    end
                end
                PH_DELAY: begin
                    if (cnt_done) begin
                        next_phase = PH_FETCH;
                        next_cnt   = LD_FETCH;
                    end else begin
                        next_cnt = cnt - 1'b1;
                    end
                end
                PH_FETCH: begin
                    if (cnt_done) begin
                        next_phase = PH_RUN;
                    end else begin
                        next_cnt = cnt - 1'b1;
                    end
                end
                PH_RUN: begin
                    next_cnt = CNT_ZERO;
                end
            endcase
        end
    end

    wire drive_next = (next_phase == PH_ACTIVE) || (next_phase == PH_DELAY);
    wire fetch_next = (next_phase == PH_FETCH);
    wire [15:0] vec_next = (next_cnt == CNT_ZERO) ? VEC_ADDR_HI : VEC_ADDR_LO;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase         <= PH_ACTIVE;
            cnt           <= LD_RSTL;
            rst_pin_oe_o  <= 1'b1;
            rst_pin_out_o <= 1'b0;
            cpu_rst_o     <= 1'b1;
            vec_fetch_o   <= 1'b0;
            vec_addr_o    <= VEC_ADDR_LO;
        end else begin
            phase         <= next_phase;
            cnt           <= next_cnt;
            rst_pin_oe_o  <= drive_next;
            rst_pin_out_o <= 1'b0;
            cpu_rst_o     <= (next_phase != PH_RUN);
            vec_fetch_o   <= fetch_next;
            vec_addr_o    <= fetch_next ? vec_next : VEC_ADDR_LO;
        end
    end

    // ****************************************************************
    // register bus
    // ****************************************************************
    wire        bus_req  = avs_req_i.read || avs_req_i.write;
    wire        wr_take  = avs_req_i.write && !avs_rsp_o.waitrequest;
    wire        lane0    = avs_req_i.byteenable[0];
    wire        hit_si   = (avs_req_i.address == OFS_SYS_INTEGRITY);
    wire        hit_opt  = (avs_req_i.address == OFS_OPTION);
    wire        hit_st   = (avs_req_i.address == OFS_STATUS);
    wire [7:0]  wdata    = avs_req_i.writedata[7:0];
    wire        si_wr    = wr_take && hit_si && lane0;
    wire        opt_wr   = wr_take && hit_opt && lane0;
    wire [2:0]  clk_wr   = wdata[OPT_CLK_LSB +: 3];
    wire        clk_ok   = (clk_wr <= CLK_SRC_RES3);

    wire [7:0]  si_rd;
    wire [7:0]  opt_rd;
    wire [7:0]  st_rd;
    assign si_rd  = {avd_src_evd_o, irq_en, warn_flag, 5'h00};
    assign opt_rd = {1'b0, osc_sel_o, opt_long, lvd_thr_o, lvd_en_o};
    assign st_rd  = {3'h0, rst_pin_oe_o, avd_irq_o, phase_code(phase)};

    wire [7:0]  rd_byte = hit_si  ? si_rd  :
                          hit_opt ? opt_rd :
                          hit_st  ? st_rd  : 8'h00;

    // one wait cycle per access: the answer register is loaded while the request stands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            avs_rsp_o.waitrequest <= 1'b1;
            avs_rsp_o.readdata    <= 32'h0000_0000;
        end else if (bus_req && avs_rsp_o.waitrequest) begin
            avs_rsp_o.waitrequest <= 1'b0;
            avs_rsp_o.readdata    <= avs_req_i.read ? {24'h000000, rd_byte} : 32'h0000_0000;
        end else begin
            avs_rsp_o.waitrequest <= 1'b1;
        end
    end

    // ****************************************************************
    // option settings
    // ****************************************************************
    // writable here so that the option set can be exercised without a fuse model;
    // they steer the detector, thresholds, reset delay and clock selection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvd_en_o  <= OPT_RST_VAL[OPT_LVD_EN_BIT];
            lvd_thr_o <= OPT_RST_VAL[OPT_THR_LSB +: 2];
            opt_long  <= OPT_RST_VAL[OPT_LONG_BIT];
            osc_sel_o <= OPT_RST_VAL[OPT_CLK_LSB +: 3];
        end else if (opt_wr) begin
            lvd_en_o  <= wdata[OPT_LVD_EN_BIT];
            lvd_thr_o <= (wdata[OPT_THR_LSB +: 2] > THR_HIGH) ? lvd_thr_o
                                                             : wdata[OPT_THR_LSB +: 2];
            opt_long  <= wdata[OPT_LONG_BIT];
            osc_sel_o <= clk_ok ? clk_wr : osc_sel_o;
        end
    end

    // resonators are never gated by the reset phase, only by the source choice
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_run_o <= 1'b0;
        end else begin
            osc_run_o <= (osc_sel_o >= CLK_SRC_RES0);
        end
    end

    // ****************************************************************
    // auxiliary voltage detector
    // ****************************************************************
    wire aux_cmp   = avd_src_evd_o ? aux_cmp_evd_i : aux_cmp_supply_i;
    wire next_flag = lvd_en_o && aux_cmp;
    wire running   = (phase == PH_RUN);
    wire toggle_ev = running && irq_en && (next_flag != warn_flag);
    wire enable_ev = running && si_wr && wdata[SI_IRQ_EN_BIT] && !irq_en && warn_flag;
    wire pend_set  = toggle_ev || enable_ev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            warn_flag <= 1'b0;
        end else begin
            warn_flag <= next_flag;
        end
    end

    // control bits return to zero for the whole reset sequence; bus writes then are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i || cpu_rst_o) begin
            avd_src_evd_o <= 1'b0;
            irq_en        <= 1'b0;
        end else if (si_wr) begin
            avd_src_evd_o <= wdata[SI_SRC_SEL_BIT];
            irq_en        <= wdata[SI_IRQ_EN_BIT];
        end
    end

    // a new event in the acknowledge cycle keeps the request pending
    always_ff @(posedge clk_i) begin
        if (rst_i || cpu_rst_o) begin
            avd_irq_o <= 1'b0;
        end else if (pend_set) begin
            avd_irq_o <= 1'b1;
        end else if (irq_ack_i) begin
            avd_irq_o <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ===== design/rsq_pkg.sv
// package for the reset sequencer and voltage monitor: constants, bus carriers, phase type
package rsq_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS   = 100;
    // minimum width of the reset pulse that the device drives out
    localparam int unsigned T_RSTL_OUT_NS   = 20000;
    localparam int unsigned RSTL_OUT_CYC    = (T_RSTL_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DLY_SHORT_CYC   = 256;
    localparam int unsigned DLY_LONG_CYC    = 4096;
    localparam int unsigned FETCH_CYC       = 2;

    // ****************************************************************
    // reset vector location
    // ****************************************************************
    localparam logic [15:0] VEC_ADDR_LO     = 16'hFFFE;
    localparam logic [15:0] VEC_ADDR_HI     = 16'hFFFF;

    // ****************************************************************
    // register map, byte addresses
    // ****************************************************************
    localparam logic [3:0]  OFS_SYS_INTEGRITY = 4'h0;
    localparam logic [3:0]  OFS_OPTION        = 4'h4;
    localparam logic [3:0]  OFS_STATUS        = 4'h8;

    // system_integrity_ctrl_status fields
    localparam int unsigned SI_SRC_SEL_BIT  = 7;
    localparam int unsigned SI_IRQ_EN_BIT   = 6;
    localparam int unsigned SI_FLAG_BIT     = 5;

    // option fields
    localparam int unsigned OPT_LVD_EN_BIT  = 0;
    localparam int unsigned OPT_THR_LSB     = 1;
    localparam int unsigned OPT_LONG_BIT    = 3;
    localparam int unsigned OPT_CLK_LSB     = 4;
    localparam logic [7:0]  OPT_RST_VAL     = 8'h09;

    // status fields
    localparam int unsigned ST_PHASE_LSB    = 0;
    localparam int unsigned ST_PEND_BIT     = 3;
    localparam int unsigned ST_PIN_BIT      = 4;

    // low_voltage_detector threshold codes
    localparam logic [1:0]  THR_LOW         = 2'h0;
    localparam logic [1:0]  THR_MEDIUM      = 2'h1;
    localparam logic [1:0]  THR_HIGH        = 2'h2;

    // main clock source codes
    localparam logic [2:0]  CLK_SRC_EXT     = 3'h0;
    localparam logic [2:0]  CLK_SRC_RC      = 3'h1;
    localparam logic [2:0]  CLK_SRC_RES0    = 3'h2;
    localparam logic [2:0]  CLK_SRC_RES3    = 3'h5;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {PH_ACTIVE, PH_RELEASE, PH_DELAY, PH_FETCH, PH_RUN} rsq_phase_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } rsq_avs_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } rsq_avs_rsp_s;

endpackage

// ===== bench/rsq_board.sv
// board side of the reset pin: weak pull-up plus an external reset holder
`timescale 1ns/10ps
`default_nettype none
module rsq_board (
    input  wire logic dev_pull_i,
    input  wire logic ext_pull_i,
    output logic      pin_o
);
    // ****
    // open-drain wire
    // ****
    // released by both parties the pull-up wins, so an idle pin reads high
    assign pin_o = (dev_pull_i || ext_pull_i) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ===== bench/rsq_reset_seq_asserts.sv
// port checker for the reset sequencer, bound to the design top
`timescale 1ns/10ps
`default_nettype none
module rsq_reset_seq_asserts #(
    parameter int unsigned RSTL_CYC  = 4,
    parameter int unsigned DLY_SHORT = 4,
    parameter int unsigned DLY_LONG  = 8
) (
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire rsq_pkg::rsq_avs_req_s avs_req_i,
    input wire logic                  rst_pin_out_o,
    input wire logic                  rst_pin_oe_o,
    input wire logic                  lvd_below_i,
    input wire logic                  lvd_en_o,
    input wire logic                  wdg_underflow_i,
    input wire logic                  aux_cmp_supply_i,
    input wire logic                  aux_cmp_evd_i,
    input wire logic                  irq_ack_i,
    input wire logic                  avd_irq_o,
    input wire logic                  cpu_rst_o,
    input wire logic                  vec_fetch_o,
    input wire logic [15:0]           vec_addr_o
);
    import rsq_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****
    // pin-low run length
    // ****
    logic [15:0] oe_run;
    always_ff @(posedge clk_i) oe_run <= (rst_i || !rst_pin_oe_o) ? 16'h0 : oe_run + 16'h1;
    property p_fetch_len; $rose(vec_fetch_o) |=> vec_fetch_o ##1 !vec_fetch_o; endproperty
    a_fetch_len: assert property (p_fetch_len) else $error("fetch length wrong");
    property p_vec_addr;
        $rose(vec_fetch_o) |-> vec_addr_o == 16'hFFFE ##1 vec_addr_o == 16'hFFFF;
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");
    property p_run_after; $fell(vec_fetch_o) |-> !cpu_rst_o; endproperty
    a_run_after: assert property (p_run_after) else $error("core not released");
    property p_wdg; wdg_underflow_i |=> rst_pin_oe_o && cpu_rst_o; endproperty
    a_wdg: assert property (p_wdg) else $error("watchdog not driving pin");
    // a low supply only counts while the detector option is on
    property p_lvd; lvd_below_i && lvd_en_o |=> rst_pin_oe_o; endproperty
    a_lvd: assert property (p_lvd) else $error("low supply not holding pin");
    property p_min_width; $fell(rst_pin_oe_o) |-> oe_run >= RSTL_CYC; endproperty
    a_min_width: assert property (p_min_width) else $error("pin pulse too short");
    property p_delay; $rose(vec_fetch_o) |-> oe_run == DLY_SHORT || oe_run == DLY_LONG; endproperty
    a_delay: assert property (p_delay) else $error("delay length wrong");
    property p_run_clean; !cpu_rst_o |-> !rst_pin_oe_o && rst_pin_out_o == 1'b0; endproperty
    a_run_clean: assert property (p_run_clean) else $error("pin driven while running");
    property p_irq_run; $rose(avd_irq_o) |-> !$past(cpu_rst_o); endproperty
    a_irq_run: assert property (p_irq_run) else $error("warning during reset");
    property p_ack;
        irq_ack_i && !avs_req_i.write && $stable(aux_cmp_supply_i) && $stable(aux_cmp_evd_i)
            |=> !avd_irq_o;
    endproperty
    a_ack: assert property (p_ack) else $error("pending not cleared");
    c_fetch: cover property ($rose(vec_fetch_o));
    c_irq: cover property ($rose(avd_irq_o));
    c_wdg: cover property (wdg_underflow_i && !cpu_rst_o);
endmodule
bind rsq_reset_seq rsq_reset_seq_asserts #(.RSTL_CYC(RSTL_CYC), .DLY_SHORT(DLY_SHORT),
    .DLY_LONG(DLY_LONG)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .avs_req_i(avs_req_i),
    .rst_pin_out_o(rst_pin_out_o), .rst_pin_oe_o(rst_pin_oe_o), .lvd_below_i(lvd_below_i),
    .lvd_en_o(lvd_en_o),
    .wdg_underflow_i(wdg_underflow_i), .aux_cmp_supply_i(aux_cmp_supply_i),
    .aux_cmp_evd_i(aux_cmp_evd_i), .irq_ack_i(irq_ack_i), .avd_irq_o(avd_irq_o),
    .cpu_rst_o(cpu_rst_o), .vec_fetch_o(vec_fetch_o), .vec_addr_o(vec_addr_o));
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the reset sequencer and voltage monitor
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import rsq_pkg::*;
    logic clk_i, rst_i, ext_low, lvd_below, wdg, cmp_sup, cmp_evd, ack, pin, pin_out, pin_oe;
    logic irq, cpu_rst, fetch, lvd_en, src_evd, osc_run;
    logic [15:0] vaddr;
    logic [1:0]  thr;
    logic [2:0]  osc;
    logic [7:0]  q;
    rsq_avs_req_s req;
    rsq_avs_rsp_s rsp;
    int fails, checked, m_flag, v;
    rsq_reset_seq #(.RSTL_CYC(4), .DLY_SHORT(4), .DLY_LONG(8)) dut_u (.clk_i(clk_i),
        .rst_i(rst_i), .avs_req_i(req), .avs_rsp_o(rsp), .rst_pin_in_i(pin),
        .rst_pin_out_o(pin_out), .rst_pin_oe_o(pin_oe), .lvd_below_i(lvd_below),
        .wdg_underflow_i(wdg), .aux_cmp_supply_i(cmp_sup), .aux_cmp_evd_i(cmp_evd),
        .irq_ack_i(ack), .avd_irq_o(irq), .cpu_rst_o(cpu_rst), .vec_fetch_o(fetch),
        .vec_addr_o(vaddr), .lvd_en_o(lvd_en), .lvd_thr_o(thr), .avd_src_evd_o(src_evd),
        .osc_sel_o(osc), .osc_run_o(osc_run));
    rsq_board brd_u (.dev_pull_i(pin_oe), .ext_pull_i(ext_low), .pin_o(pin));
    // ****
    // tasks
    // ****
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // request held until waitrequest is sampled low at an edge; only the watchdog ends a hang
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        req <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}, byteenable: 4'hF};
        do begin @(posedge clk_i); end while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata[7:0];
        req <= '0;
        @(posedge clk_i);
    endtask
    // counts the pin-low run that ends where the fetch starts
    task automatic seq(input int dly);
        int n, run;
        n = 0;
        run = 0;
        do begin
            @(posedge clk_i);
            if (fetch !== 1'b1) run = (pin_oe === 1'b1) ? run + 1 : 0;
            n++;
        end while (fetch !== 1'b1 && n < 5000);
        chk("delay", run, dly);
        chk("vec lo", vaddr, 16'hFFFE);
        @(posedge clk_i);
        chk("vec hi", {fetch, vaddr}, 17'h1FFFF);
        @(posedge clk_i);
        chk("run", {fetch, cpu_rst, pin}, 3'h1);
    endtask
    initial begin clk_i = 1'b0; forever #50 clk_i = ~clk_i; end
    initial begin #3000000; fails++; end_sim(); end
    // ****
    // scenarios
    // ****
    initial begin
        void'($urandom(32'h8fb35a52));
        {rst_i, ext_low, lvd_below, wdg, cmp_sup, cmp_evd, ack} = 7'h40;
        req = '0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        seq(8);
        bus(1'b0, OFS_OPTION, 8'h00); chk("option", q, OPT_RST_VAL);
        bus(1'b0, 4'hC, 8'h00); chk("unmapped", q, 8'h00);
        for (int t = 0; t < 3; t++) begin
            bus(1'b1, OFS_OPTION, 8'h01 | 8'(t << 1)); chk("thr", thr, t);
        end
        for (int c = 0; c < 6; c++) begin
            bus(1'b1, OFS_OPTION, {1'b0, 3'(c), 4'h1});
            @(posedge clk_i);
            chk("osc", {osc_run, osc}, {c >= 2, 3'(c)});
        end
        wdg <= 1'b1; @(posedge clk_i); wdg <= 1'b0; seq(4);
        lvd_below <= 1'b1; repeat (20) @(posedge clk_i);
        chk("lvd hold", {pin_oe, cpu_rst, pin, pin_out}, 4'hC);
        lvd_below <= 1'b0; seq(4);
        ext_low <= 1'b1; repeat (5) @(posedge clk_i); ext_low <= 1'b0; @(posedge clk_i);
        @(posedge clk_i); chk("stretch", {pin_oe, pin}, 2'h2);
        seq(4);
        bus(1'b1, OFS_SYS_INTEGRITY, 8'h40);
        m_flag = 0;
        for (int i = 0; i < 4; i++) begin
            cmp_sup <= ~cmp_sup; m_flag ^= 1; repeat (2) @(posedge clk_i);
            chk("irq", irq, 1'b1);
            bus(1'b0, OFS_SYS_INTEGRITY, 8'h00); chk("flag", q[5], m_flag[0]);
            ack <= 1'b1; @(posedge clk_i); ack <= 1'b0; @(posedge clk_i);
            chk("ack", irq, 1'b0);
        end
        bus(1'b1, OFS_SYS_INTEGRITY, 8'h00);
        cmp_sup <= 1'b1; repeat (2) @(posedge clk_i); chk("masked", irq, 1'b0);
        bus(1'b1, OFS_SYS_INTEGRITY, 8'h40); chk("enable irq", irq, 1'b1);
        ack <= 1'b1; @(posedge clk_i); ack <= 1'b0; cmp_sup <= 1'b0;
        repeat (2) @(posedge clk_i); chk("second irq", irq, 1'b1);
        ack <= 1'b1; @(posedge clk_i); ack <= 1'b0;
        bus(1'b1, OFS_SYS_INTEGRITY, 8'h80); chk("src", {src_evd, irq}, 2'h2);
        for (int i = 0; i < 4; i++) begin
            v = $urandom % 2;
            cmp_evd <= v[0]; cmp_sup <= ~v[0]; repeat (2) @(posedge clk_i);
            bus(1'b0, OFS_SYS_INTEGRITY, 8'h00); chk("evd flag", q[5], v[0]);
        end
        bus(1'b1, OFS_OPTION, 8'h00); cmp_evd <= 1'b1; lvd_below <= 1'b1;
        repeat (5) @(posedge clk_i);
        bus(1'b0, OFS_SYS_INTEGRITY, 8'h00); chk("lvd off", {lvd_en, q[5], cpu_rst}, 3'h0);
        lvd_below <= 1'b0;
        bus(1'b1, OFS_OPTION, 8'h01); bus(1'b1, OFS_SYS_INTEGRITY, 8'h40);
        wdg <= 1'b1; @(posedge clk_i); wdg <= 1'b0; cmp_sup <= 1'b1;
        seq(4); chk("no irq", irq, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
